// file: rtl/npebm_consts.svh
// constants for the nand program/erase host: command bytes, marker
// layout, block counts and busy-time budgets.
// assumes a 40 MHz core clock and an 8-bit wide nand data bus.
`ifndef NPEBM_CONSTS_SVH
`define NPEBM_CONSTS_SVH

// ************************************************************
// command bytes
// ************************************************************
`define NPEBM_CMD_READ1      8'h00
`define NPEBM_CMD_READ2      8'h30
`define NPEBM_CMD_PROG1      8'h80
`define NPEBM_CMD_PROG2      8'h10
`define NPEBM_CMD_ERASE1     8'h60
`define NPEBM_CMD_ERASE2     8'hD0
`define NPEBM_CMD_STATUS     8'h70

// ************************************************************
// fields, markers and counts
// ************************************************************
`define NPEBM_STAT_FAIL_BIT  0
`define NPEBM_MARK_ERASED    8'hFF
`define NPEBM_MARK_COL       12'h800
`define NPEBM_LAST_BLOCK     12'hFFF
`define NPEBM_MIN_VALID      4016
`define NPEBM_PARTIAL_LIMIT  3'h4
`define NPEBM_ECC_SECTOR     528
`define NPEBM_ADDR_ROW0      3'h2
`define NPEBM_ADDR_LAST      3'h4
`define NPEBM_RD_RE_PH       3'h2
`define NPEBM_RD_SAMPLE_PH   3'h6
`define NPEBM_PINS_IDLE      15'h4D00

// ************************************************************
// timing
// ************************************************************
`define NPEBM_CLK_PERIOD_NS  25
`define NPEBM_T_WB_NS        100
`define NPEBM_T_RHW_NS       100
`define NPEBM_T_R_US         25
`define NPEBM_T_PROG_MAX_US  700
`define NPEBM_T_CLEAR_MAX_MS 10
`define NPEBM_WB_CYC  ((`NPEBM_T_WB_NS + `NPEBM_CLK_PERIOD_NS - 1) / `NPEBM_CLK_PERIOD_NS)
`define NPEBM_RHW_CYC ((`NPEBM_T_RHW_NS + `NPEBM_CLK_PERIOD_NS - 1) / `NPEBM_CLK_PERIOD_NS)
`define NPEBM_R_CYC   (`NPEBM_T_R_US * 1000 / `NPEBM_CLK_PERIOD_NS)
`define NPEBM_PROG_CYC (`NPEBM_T_PROG_MAX_US * 1000 / `NPEBM_CLK_PERIOD_NS)
`define NPEBM_CLEAR_CYC (`NPEBM_T_CLEAR_MAX_MS * 1000000 / `NPEBM_CLK_PERIOD_NS)

`endif

// file: rtl/npebm_pkg.sv
// types for the nand program/erase host: requests, results, pins, state.
// assumes npebm_consts.svh for all numeric values.
package npebm_pkg;

	// ************************************************************
	// enumerations
	// ************************************************************
	typedef enum logic [1:0] {
		OP_PROG  = 2'b00,
		OP_ERASE = 2'b01,
		OP_READ  = 2'b10,
		OP_SCAN  = 2'b11
	} npebm_op_t;

	typedef enum logic [2:0] {
		RES_OK        = 3'b000,
		RES_FAIL      = 3'b001,
		RES_BAD_BLOCK = 3'b010,
		RES_ORDER     = 3'b011,
		RES_PARTIAL   = 3'b100,
		RES_NO_SCAN   = 3'b101,
		RES_TIMEOUT   = 3'b110
	} npebm_res_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_CMD1  = 4'b0001,
		ST_ADDR  = 4'b0010,
		ST_WDAT  = 4'b0011,
		ST_CMD2  = 4'b0100,
		ST_WB    = 4'b0101,
		ST_BUSY  = 4'b0110,
		ST_STCMD = 4'b0111,
		ST_STRD  = 4'b1000,
		ST_RDAT  = 4'b1001,
		ST_DONE  = 4'b1010
	} npebm_state_t;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		npebm_op_t   op;
		logic [11:0] block;
		logic [5:0]  page;
		logic [11:0] col;
		logic [11:0] len;
	} npebm_req_t;

	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic       wp_n;
		logic       io_oe_n;
		logic [7:0] io_out;
	} npebm_pins_t;

	typedef struct packed {
		npebm_state_t state;
		logic [2:0]   ph;
		logic [2:0]   acnt;
		logic [11:0]  cnt;
		logic [18:0]  tmo;
		npebm_req_t   req;
		npebm_pins_t  pins;
		logic         req_ready;
		logic         rsp_valid;
		npebm_res_t   rsp_code;
		npebm_res_t   res;
		logic         wr_ready;
		logic [7:0]   rd_data;
		logic         rd_valid;
		logic [17:0]  ecc_code;
		logic         ecc_valid;
		logic [9:0]   sec;
		logic [9:0]   idx_acc;
		logic [7:0]   col_acc;
		logic         scan_done;
		logic [12:0]  valid_cnt;
		logic         block0_bad;
		logic         too_few;
		logic         bad;
		logic         open;
		logic [11:0]  last_blk;
		logic [5:0]   last_pg;
		logic [2:0]   pcnt;
	} npebm_st_t;

endpackage : npebm_pkg

// file: rtl/npebm_host.sv
// host-side controller for an asynchronous nand flash: bad-block scan,
// page program, block erase and page read with status checks.
// assumes the nand pins are wired straight out; io and ready/busy come
// from the pins and are synchronised here.
// Functional notes
// RULE1: at most four partial programs per page
// RULE2: page program busy up to 700 us
// RULE3: feature access busy up to 1 us
// RULE4: locked block rejected within 3 us
// RULE5: protected otp program rejected within 30 us
// RULE6: two-plane intermediate busy up to 1 us
// RULE7: block zero ships valid
// RULE8: at least 4016 of 4096 blocks valid
// RULE9: factory bad blocks carry non-ff marker
// RULE10: scan markers before any program or erase
// RULE11: read status after program/erase, retire failures
// RULE12: ecc of one bit per 528 bytes
// RULE13: program pages ascending within a block
// RULE14: on failure relocate block, record it bad; the code records it bad and answers RES_FAIL, no relocation
// RULE15: device shows busy until interval ends
`timescale 1ns/10ps
`include "npebm_consts.svh"

module npebm_host
	import npebm_pkg::*;
#(
	parameter int PROG_TMO_CYC  = `NPEBM_PROG_CYC,
	parameter int CLEAR_TMO_CYC = `NPEBM_CLEAR_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic        req_valid,
	input  wire npebm_req_t  req,
	output wire logic        req_ready,
	output wire logic        rsp_valid,
	output wire npebm_res_t  rsp_code,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_valid,
	output wire logic        wr_ready,
	output wire logic [7:0]  rd_data,
	output wire logic        rd_valid,
	output wire logic [17:0] ecc_code,
	output wire logic        ecc_valid,
	output wire npebm_pins_t nand_pins,
	input  wire logic [7:0]  io_in,
	input  wire logic        rb_in,
	output wire logic        scan_done,
	output wire logic [12:0] valid_blocks,
	output wire logic        too_few_valid,
	output wire logic        block0_bad
);

	// ************************************************************
	// declarations
	// ************************************************************
	npebm_st_t   r;              // registered state
	npebm_st_t   n;              // next state
	logic        bbt [4096];     // bad-block table, one bit per block
	logic        bbt_we;         // table write strobe
	logic        bbt_val;        // table write value
	logic [7:0]  io_s1;          // io synchroniser, first stage
	logic [7:0]  io_s2;          // io synchroniser, second stage
	logic        rb_s1;          // ready/busy synchroniser, first stage
	logic        rb_s2;          // ready/busy, synchronised
	logic        ecc_go;         // one byte enters the ecc sector
	logic [7:0]  ecc_byte;       // that byte
	logic [9:0]  ecc_idx;        // index accumulator after this byte
	logic [7:0]  ecc_col;        // column accumulator after this byte
	logic [7:0]  wbyte;          // byte placed on io by a write cycle
	logic        wcle;           // command latch for a write cycle
	logic        wale;           // address latch for a write cycle
	logic        wgo;            // write cycle may start
	logic        same;           // request targets the open block
	logic        bad_n;          // marker state of the scanned block
	logic [17:0] row;            // row address, block then page
	logic [18:0] tmo_lim;        // busy wait budget of the running op

	// drive one write cycle: chip selected, we low, data driven
	function automatic npebm_pins_t drive_wr(input logic c, input logic a,
		input logic [7:0] b, input logic wp_n);
		npebm_pins_t p;
		p.ce_n    = 1'b0;
		p.cle     = c;
		p.ale     = a;
		p.we_n    = 1'b0;
		p.re_n    = 1'b1;
		p.wp_n    = wp_n;
		p.io_oe_n = 1'b0;
		p.io_out  = b;
		return p;
	endfunction : drive_wr

	// ************************************************************
	// sequencer next state
	// ************************************************************
	always_comb begin
		n         = r;
		n.rsp_valid = 1'b0;
		n.rd_valid  = 1'b0;
		n.ecc_valid = 1'b0;
		n.req_ready = 1'b0;
		n.wr_ready  = 1'b0;
		bbt_we    = 1'b0;
		bbt_val   = 1'b0;
		ecc_go    = 1'b0;
		ecc_byte  = 8'h00;
		ecc_idx   = r.idx_acc;
		ecc_col   = r.col_acc;
		wbyte     = 8'h00;
		wcle      = 1'b0;
		wale      = 1'b0;
		wgo       = 1'b0;
		bad_n     = r.bad | (io_s2 != `NPEBM_MARK_ERASED);  // RULE9
		row       = {r.req.block, r.req.page};
		same      = r.open && (req.block == r.last_blk);
		// waits bounded by the device's longest busy time
		case (r.req.op)
			OP_PROG:  tmo_lim = 19'(PROG_TMO_CYC);  // RULE2
			OP_ERASE: tmo_lim = 19'(CLEAR_TMO_CYC);
			default:  tmo_lim = 19'(`NPEBM_R_CYC);
		endcase
		case (r.state)
			// idle: accept and screen a request
			ST_IDLE: begin
				n.pins      = `NPEBM_PINS_IDLE;
				n.pins.wp_n = r.scan_done;  // RULE10
				n.req_ready = 1'b1;
				if (req_valid && r.req_ready) begin
					n.req_ready = 1'b0;
					n.req     = req;
					n.cnt     = 12'h000;
					n.tmo     = 19'h00000;
					n.sec     = 10'h000;
					n.idx_acc = 10'h000;
					n.col_acc = 8'h00;
					n.res     = RES_OK;
					n.state   = ST_CMD1;
					case (req.op)
						OP_SCAN: begin
							n.req.block  = 12'h000;
							n.req.page   = 6'h00;
							n.req.col    = `NPEBM_MARK_COL;
							n.req.len    = 12'h001;
							n.scan_done  = 1'b0;
							n.valid_cnt  = 13'h0000;
							n.block0_bad = 1'b0;
							n.bad        = 1'b0;
							n.open       = 1'b0;
						end
						OP_PROG: begin
							if (!r.scan_done) begin
								n.res   = RES_NO_SCAN;  // RULE10
								n.state = ST_DONE;
							end else if (bbt[req.block]) begin
								n.res   = RES_BAD_BLOCK;  // RULE14
								n.state = ST_DONE;
							end else if (same && req.page < r.last_pg) begin
								n.res   = RES_ORDER;  // RULE13
								n.state = ST_DONE;
							end else if (same && req.page == r.last_pg &&
								r.pcnt == `NPEBM_PARTIAL_LIMIT) begin
								n.res   = RES_PARTIAL;  // RULE1
								n.state = ST_DONE;
							end else begin
								n.open     = 1'b1;
								n.last_blk = req.block;
								n.last_pg  = req.page;
								n.pcnt     = (same && req.page == r.last_pg) ?
									r.pcnt + 3'h1 : 3'h1;
							end
						end
						OP_ERASE: begin
							if (!r.scan_done) begin
								n.res   = RES_NO_SCAN;  // RULE10
								n.state = ST_DONE;
							end else if (bbt[req.block]) begin
								n.res   = RES_BAD_BLOCK;
								n.state = ST_DONE;
							end else if (same) begin
								n.open = 1'b0;
							end
						end
						default: begin
						end
					endcase
				end
			end
			// write cycles: commands, address bytes, data bytes
			ST_CMD1, ST_ADDR, ST_WDAT, ST_CMD2, ST_STCMD: begin
				case (r.state)
					ST_CMD1: begin
						wcle  = 1'b1;
						wbyte = (r.req.op == OP_PROG) ? `NPEBM_CMD_PROG1 :
							(r.req.op == OP_ERASE) ? `NPEBM_CMD_ERASE1 :
							`NPEBM_CMD_READ1;
						wgo   = (r.tmo == 19'(`NPEBM_RHW_CYC));
					end
					ST_CMD2: begin
						wcle  = 1'b1;
						wbyte = (r.req.op == OP_PROG) ? `NPEBM_CMD_PROG2 :
							(r.req.op == OP_ERASE) ? `NPEBM_CMD_ERASE2 :
							`NPEBM_CMD_READ2;
						wgo   = 1'b1;
					end
					ST_STCMD: begin
						wcle  = 1'b1;
						wbyte = `NPEBM_CMD_STATUS;  // RULE11
						wgo   = 1'b1;
					end
					ST_ADDR: begin
						wale = 1'b1;
						wgo  = 1'b1;
						case (r.acnt)
							3'h0:    wbyte = r.req.col[7:0];
							3'h1:    wbyte = {4'h0, r.req.col[11:8]};
							3'h2:    wbyte = row[7:0];
							3'h3:    wbyte = row[15:8];
							default: wbyte = {6'h00, row[17:16]};
						endcase
					end
					default: begin
						wbyte = wr_data;
						wgo   = wr_valid && r.wr_ready;
					end
				endcase
				if (r.ph == 3'h0) begin
					if (wgo) begin
						n.pins = drive_wr(wcle, wale, wbyte, r.scan_done);
						n.ph   = 3'h1;
						ecc_go   = (r.state == ST_WDAT);  // RULE12
						ecc_byte = wr_data;
					end else begin
						n.wr_ready = (r.state == ST_WDAT);
						n.tmo      = r.tmo + 19'h00001;
					end
				end else if (r.ph == 3'h1) begin
					n.pins.we_n = 1'b1;
					n.ph        = 3'h2;
				end else begin
					n.ph = 3'h0;
					case (r.state)
						ST_CMD1: begin
							n.acnt  = (r.req.op == OP_ERASE) ?
								`NPEBM_ADDR_ROW0 : 3'h0;
							n.state = ST_ADDR;
						end
						ST_ADDR: begin
							if (r.acnt != `NPEBM_ADDR_LAST) begin
								n.acnt = r.acnt + 3'h1;
							end else if (r.req.op == OP_PROG) begin
								n.state    = ST_WDAT;
								n.wr_ready = 1'b1;
							end else begin
								n.state = ST_CMD2;
							end
						end
						ST_WDAT: begin
							if (r.cnt == r.req.len - 12'h001) begin
								n.state = ST_CMD2;
								n.cnt   = 12'h000;
							end else begin
								n.cnt      = r.cnt + 12'h001;
								n.wr_ready = 1'b1;
							end
						end
						ST_CMD2: begin
							n.state = ST_WB;
							n.tmo   = 19'h00000;
						end
						default: n.state = ST_STRD;
					endcase
				end
			end
			// hold off ready/busy until the device has gone busy
			ST_WB: begin
				n.tmo = r.tmo + 19'h00001;
				if (r.tmo == 19'(`NPEBM_WB_CYC - 1)) begin
					n.state = ST_BUSY;
					n.tmo   = 19'h00000;
				end
			end
			// wait for ready, bounded by the longest busy time
			ST_BUSY: begin
				if (rb_s2) begin  // RULE15
					n.state = (r.req.op == OP_PROG || r.req.op == OP_ERASE) ?
						ST_STCMD : ST_RDAT;
					n.cnt   = 12'h000;
				end else if (r.tmo == tmo_lim) begin
					n.res   = RES_TIMEOUT;
					n.state = ST_DONE;
				end else begin
					n.tmo = r.tmo + 19'h00001;
				end
			end
			// read cycles: status byte or data bytes
			ST_STRD, ST_RDAT: begin
				n.pins.io_oe_n = 1'b1;
				n.pins.cle     = 1'b0;
				n.pins.ale     = 1'b0;
				n.ph           = r.ph + 3'h1;
				if (r.ph == `NPEBM_RD_RE_PH) begin
					n.pins.re_n = 1'b0;
				end
				if (r.ph == `NPEBM_RD_SAMPLE_PH) begin
					n.pins.re_n = 1'b1;
					n.ph        = 3'h0;
					n.tmo       = 19'h00000;
					if (r.state == ST_STRD) begin
						n.state = ST_DONE;
						if (io_s2[`NPEBM_STAT_FAIL_BIT]) begin
							bbt_we      = 1'b1;  // RULE11
							bbt_val     = 1'b1;  // RULE14
							n.res       = RES_FAIL;
							n.valid_cnt = r.valid_cnt - 13'h0001;  // RULE8
							n.open      = r.open && (r.req.block != r.last_blk);
						end
					end else if (r.req.op == OP_SCAN) begin
						if (r.req.page == 6'h00) begin
							n.bad      = bad_n;
							n.req.page = 6'h01;
							n.state    = ST_CMD1;
						end else begin
							bbt_we      = 1'b1;  // RULE10
							bbt_val     = bad_n;
							n.valid_cnt = r.valid_cnt + {12'h000, !bad_n};
							n.block0_bad = r.block0_bad ||
								(r.req.block == 12'h000 && bad_n);  // RULE7
							n.bad       = 1'b0;
							n.req.page  = 6'h00;
							if (r.req.block == `NPEBM_LAST_BLOCK) begin
								n.scan_done = 1'b1;
								n.state     = ST_DONE;
							end else begin
								n.req.block = r.req.block + 12'h001;
								n.state     = ST_CMD1;
							end
						end
					end else begin
						n.rd_data  = io_s2;
						n.rd_valid = 1'b1;
						ecc_go     = 1'b1;  // RULE12
						ecc_byte   = io_s2;
						n.cnt      = r.cnt + 12'h001;
						if (r.cnt == r.req.len - 12'h001) begin
							n.state = ST_DONE;
						end
					end
				end
			end
			// report the result and release the chip
			ST_DONE: begin
				n.pins      = `NPEBM_PINS_IDLE;
				n.pins.wp_n = r.scan_done;
				n.rsp_valid = 1'b1;
				n.rsp_code  = r.res;
				n.state     = ST_IDLE;
			end
			default: n.state = ST_IDLE;
		endcase
		// single-bit locating code over each sector of bytes
		if (ecc_go) begin
			ecc_col = r.col_acc ^ ecc_byte;
			ecc_idx = (^ecc_byte) ? (r.idx_acc ^ r.sec) : r.idx_acc;
			if (r.sec == 10'(`NPEBM_ECC_SECTOR - 1)) begin
				n.ecc_code  = {ecc_idx, ecc_col};  // RULE12
				n.ecc_valid = 1'b1;
				n.sec       = 10'h000;
				n.idx_acc   = 10'h000;
				n.col_acc   = 8'h00;
			end else begin
				n.sec     = r.sec + 10'h001;
				n.idx_acc = ecc_idx;
				n.col_acc = ecc_col;
			end
		end
		n.too_few = n.scan_done &&
			(n.valid_cnt < 13'(`NPEBM_MIN_VALID));  // RULE8
	end

	// ************************************************************
	// registers
	// ************************************************************
	// sequencer state, frozen while clk_en is low
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r      <= '0;
			r.pins <= `NPEBM_PINS_IDLE;
		end else if (clk_en) begin
			r <= n;
		end
	end

	// pin synchronisers, two stages each
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
		end else if (clk_en) begin
			io_s1 <= io_in;
			io_s2 <= io_s1;
			rb_s1 <= rb_in;
			rb_s2 <= rb_s1;
		end
	end

	// bad-block table, rebuilt by every scan
	always_ff @(posedge core_clk) begin
		if (clk_en && bbt_we) begin
			bbt[r.req.block] <= bbt_val;
		end
	end

	assign req_ready     = r.req_ready;
	assign rsp_valid     = r.rsp_valid;
	assign rsp_code      = r.rsp_code;
	assign wr_ready      = r.wr_ready;
	assign rd_data       = r.rd_data;
	assign rd_valid      = r.rd_valid;
	assign ecc_code      = r.ecc_code;
	assign ecc_valid     = r.ecc_valid;
	assign nand_pins     = r.pins;
	assign scan_done     = r.scan_done;
	assign valid_blocks  = r.valid_cnt;
	assign too_few_valid = r.too_few;
	assign block0_bad    = r.block0_bad;

endmodule : npebm_host

// file: bench/npebm_host_asserts.sv
// checker for the nand host: request handshake, refusals before a scan,
// pin strobe shapes and pulse outputs.
// assumes it is bound into npebm_host and sees only its ports.
`timescale 1ns/10ps
module npebm_host_asserts
	import npebm_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        clk_en,
	input wire logic        req_valid,
	input wire npebm_req_t  req,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire npebm_res_t  rsp_code,
	input wire logic        ecc_valid,
	input wire npebm_pins_t nand_pins,
	input wire logic        scan_done,
	input wire logic [12:0] valid_blocks,
	input wire logic        too_few_valid
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic take;  // a request is taken at this edge
	assign take = req_valid && req_ready && clk_en;
	// program or erase before a scan is refused two cycles later
	no_scan_refuse_a: assert property (take && !scan_done &&
		(req.op == OP_PROG || req.op == OP_ERASE) |-> ##2
		(rsp_valid && rsp_code == RES_NO_SCAN)) else $error("no refusal");
	wp_hold_a: assert property (!scan_done |-> !nand_pins.wp_n)
		else $error("write protect released before scan");
	few_valid_a: assert property (too_few_valid |->
		scan_done && valid_blocks < 13'h0FB0) else $error("bad count flag");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	one_request_a: assert property (take |=> !req_ready[*2])
		else $error("ready while a request is open");
	ecc_pulse_a: assert property (ecc_valid |=> !ecc_valid[*8])
		else $error("ecc pulse repeated");
	we_shape_a: assert property (!nand_pins.we_n |=> nand_pins.we_n[*2])
		else $error("write strobe shape");
	re_shape_a: assert property ($fell(nand_pins.re_n) |->
		!nand_pins.re_n[*4] ##1 nand_pins.re_n) else $error("read strobe");
	latch_excl_a: assert property (!(nand_pins.cle && nand_pins.ale))
		else $error("command and address latch together");
	rd_release_a: assert property (!nand_pins.re_n |->
		!nand_pins.ce_n && nand_pins.io_oe_n) else $error("bus clash");
	// main scenarios reached
	cover property (take && req.op == OP_READ);
	cover property (ecc_valid);
	cover property (rsp_valid && rsp_code == RES_NO_SCAN);
endmodule : npebm_host_asserts
bind npebm_host npebm_host_asserts i_npebm_host_asserts (.*);

// file: bench/npebm_dev.sv
// behavioural nand device: latches commands and addresses on write
// strobe rises, answers page and status reads, shows busy on rb.
// assumes the bench resolves the shared io wire into io_bus.
`timescale 1ns/10ps
module npebm_dev
	import npebm_pkg::*;
#(
	parameter int T_RD_NS   = 2000,
	parameter int T_PROG_NS = 1000, // inside 1 us
	parameter int BAD_BLK   = 3
) (
	input  wire npebm_pins_t pins,
	input  wire logic [7:0]  io_bus,
	output logic [7:0]       dev_io,
	output logic             rb_out
);
	// ************************************************************
	// array model
	// ************************************************************
	logic [39:0] addr_sh;  // address bytes, first one lowest
	logic [7:0]  dout = 8'hA5; // byte shown while re_n is low
	logic        stat_md;  // status read selected
	int          col;      // read column pointer
	int          col_st;   // start column of the last read
	int          prev_col; // start column of the read before
	logic [17:0] row;      // row of the last read
	logic [17:0] prev_row; // row of the read before
	int          n_rd = 0; // page reads started
	int          n_cmd = 0; // command bytes seen
	initial rb_out = 1'b1;
	// page bytes are a pattern, the spare marker flags one block only
	function automatic logic [7:0] peek(int c, logic [17:0] r);
		if (c < 12'h800) begin
			return c[7:0] ^ r[7:0];
		end
		return (c == 12'h800 && r[17:6] == BAD_BLK[11:0]) ?
			8'h00 : 8'hFF;
	endfunction : peek
	// latch on write strobe rise; busy holds rb low for its interval
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.ale) begin
			addr_sh = {io_bus, addr_sh[39:8]};
		end else if (!pins.ce_n && pins.cle) begin
			n_cmd++;
			stat_md = (io_bus == 8'h70);
			if (io_bus == 8'h30) begin
				prev_row = row;
				prev_col = col_st;
				col_st = addr_sh[11:0];
				col = col_st;
				row = addr_sh[33:16];
				n_rd++;
				rb_out = 1'b0;
				#(T_RD_NS) rb_out = 1'b1;
			end else if (io_bus == 8'h10 || io_bus == 8'hD0) begin
				rb_out = 1'b0;
				#(T_PROG_NS) rb_out = 1'b1;
			end
		end
	end
	// status shows not-ready until the interval ends, fail bit clear
	always @(negedge pins.re_n) begin
		dout = stat_md ? (rb_out ? 8'hE0 : 8'hA0) : peek(col, row);
	end
	// column advances as each byte is released
	always @(posedge pins.re_n) begin
		if (!stat_md) col++;
	end
	// a released bus shows the inverse of the last byte
	assign dev_io = (!pins.ce_n && !pins.re_n) ? dout : ~dout;
endmodule : npebm_dev

// file: bench/npebm_host_test.sv
// self-checking bench for the nand host: refusals before a scan, clock
// freeze, a full-sector page read and a scan cut short by reset.
// assumes npebm_dev stands for the flash on the pins.
`timescale 1ns/10ps
`include "npebm_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	err_total++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module npebm_host_test
	import npebm_pkg::*;
;
	// ************************************************************
	// stimulus and wiring
	// ************************************************************
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        req_valid = 1'b0;
	npebm_req_t  req = '0;
	logic        req_ready, rsp_valid, rd_valid, ecc_valid, scan_done;
	npebm_res_t  rsp_code;
	logic [7:0]  rd_data, io_in, dev_io;
	logic [17:0] ecc_code;
	npebm_pins_t nand_pins;
	logic [12:0] valid_blocks;
	logic        too_few_valid, block0_bad, rb_in;
	int          err_total = 0, n_checks = 0, cyc_cnt = 0, n_rdv, n_ecc;
	int          ex_col, ex_idx; // expected ecc accumulators
	always #12.5 core_clk = ~core_clk;
	// wire level: host drives io while its enable is low
	assign io_in = nand_pins.io_oe_n ? dev_io : nand_pins.io_out;
	npebm_host #(.PROG_TMO_CYC(50), .CLEAR_TMO_CYC(80)) i_npebm_host (
		.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_code(rsp_code), .wr_data(8'h00),
		.wr_valid(1'b0), .wr_ready(), .rd_data(rd_data),
		.rd_valid(rd_valid), .ecc_code(ecc_code), .ecc_valid(ecc_valid),
		.nand_pins(nand_pins), .io_in(io_in), .rb_in(rb_in),
		.scan_done(scan_done), .valid_blocks(valid_blocks),
		.too_few_valid(too_few_valid), .block0_bad(block0_bad));
	npebm_dev i_npebm_dev (.pins(nand_pins), .io_bus(io_in),
		.dev_io(dev_io), .rb_out(rb_in));
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	// offer a request and hold it until the host takes it
	task automatic send(logic [43:0] r);
		req_valid <= 1'b1;
		req <= r;
		for (int i = 0; i < 50; i++) begin
			@(negedge core_clk);
			if (req_ready === 1'b1) break;
		end
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask : send
	// wait for the answer, checking read bytes and counting ecc pulses
	task automatic wait_rsp(int lim, logic [7:0] r8);
		n_rdv = 0;
		n_ecc = 0;
		ex_col = 0;
		ex_idx = 0;
		repeat (lim) begin
			@(negedge core_clk);
			if (rd_valid === 1'b1) begin
				`CHK("rd_data", n_rdv[7:0] ^ r8, rd_data)
				if (^(n_rdv[7:0] ^ r8)) ex_idx ^= n_rdv;
				ex_col ^= n_rdv[7:0] ^ r8;
				n_rdv++;
			end
			if (ecc_valid === 1'b1) n_ecc++;
			if (rsp_valid === 1'b1) break;
		end
		`CHK("rsp_valid", 1'b1, rsp_valid)
	endtask : wait_rsp
	// outputs while reset is held
	task automatic t_reset();
		`CHK("ce_n", 1'b1, nand_pins.ce_n)
		`CHK("wp_n", 1'b0, nand_pins.wp_n)
		`CHK("req_ready", 1'b0, req_ready)
		`CHK("scan_done", 1'b0, scan_done)
		$display("test reset done");
	endtask : t_reset
	// program and erase before a scan, back to back, reach no pins
	task automatic t_refuse();
		int c0;
		c0 = i_npebm_dev.n_cmd;
		for (int k = 0; k < 2; k++) begin
			send({k[1:0], 12'h005, 6'h00, 12'h000, 12'h001});
			wait_rsp(4, 8'h00);
			`CHK("refuse code", RES_NO_SCAN, rsp_code)
			@(posedge core_clk);
		end
		`CHK("commands sent", c0, i_npebm_dev.n_cmd)
		$display("test refuse done");
	endtask : t_refuse
	// a frozen clock enable keeps a pending request untaken
	task automatic t_freeze();
		clk_en <= 1'b0;
		req_valid <= 1'b1;
		req <= {OP_PROG, 12'h007, 6'h01, 12'h000, 12'h001};
		repeat (4) begin
			@(negedge core_clk);
			`CHK("frozen rsp", 1'b0, rsp_valid)
		end
		@(posedge core_clk);
		clk_en <= 1'b1;
		send(req);
		wait_rsp(4, 8'h00);
		`CHK("freeze code", RES_NO_SCAN, rsp_code)
		@(posedge core_clk);
		$display("test freeze done");
	endtask : t_freeze
	// one full sector read: every byte, one ecc pulse, right row
	task automatic t_read();
		send({OP_READ, 12'h005, 6'h03, 12'h000, 12'h210});
		wait_rsp(8000, 8'h43);
		`CHK("read code", RES_OK, rsp_code)
		`CHK("bytes read", `NPEBM_ECC_SECTOR, n_rdv)
		`CHK("ecc pulses", 32'h1, n_ecc)
		`CHK("ecc code", {ex_idx[9:0], ex_col[7:0]}, ecc_code)
		`CHK("read row", 18'h00143, i_npebm_dev.row)
		@(posedge core_clk);
		$display("test read done");
	endtask : t_read
	// scan reads the marker on page 0 then page 1; reset cuts it short
	task automatic t_scan();
		int r0;
		r0 = i_npebm_dev.n_rd;
		send({OP_SCAN, 12'h000, 6'h00, 12'h000, 12'h001});
		for (int i = 0; i < 4000 && i_npebm_dev.n_rd < r0 + 2; i++)
			@(posedge core_clk);
		`CHK("mark col 0", 32'h800, i_npebm_dev.prev_col)
		`CHK("mark row 0", 18'h00000, i_npebm_dev.prev_row)
		`CHK("mark col 1", 32'h800, i_npebm_dev.col_st)
		`CHK("mark row 1", 18'h00001, i_npebm_dev.row)
		arst_n <= 1'b0;
		repeat (20) @(posedge core_clk);
		t_reset();
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		$display("test scan done");
	endtask : t_scan
	// ************************************************************
	// sequence and watchdog
	// ************************************************************
	initial begin
		repeat (20) @(posedge core_clk);
		t_reset();
		arst_n <= 1'b1;
		repeat (2) @(negedge core_clk);
		`CHK("ready after reset", 1'b1, req_ready)
		@(posedge core_clk);
		t_refuse();
		t_freeze();
		t_read();
		t_scan();
		t_refuse();
		close_out();
	end
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			close_out();
		end
	end
endmodule : npebm_host_test
